// ===== logic/pseb_pkg.sv
// Package: offsets, field positions and reset values of the status bank
package pseb_pkg;
   localparam int NUM_IF = 3;
   localparam logic [8:0] OFF_PAGE_SELECT_CONTROL = 9'h000;
   localparam logic [8:0] OFF_PAGE_SELECT_CONTROL_P1 = 9'h080;
   localparam logic [8:0] OFF_SYS_STATUS = 9'h001;
   localparam logic [8:0] OFF_GPI_LO = 9'h002;
   localparam logic [8:0] OFF_GPI_HI = 9'h003;
   localparam logic [8:0] OFF_CUR_LIM = 9'h004;
   localparam logic [8:0] OFF_FAULT_LOG = 9'h005;
   localparam logic [8:0] OFF_EVENT_A = 9'h006;
   localparam logic [8:0] OFF_EVENT_B = 9'h007;
   localparam logic [8:0] OFF_EVENT_C = 9'h008;
   localparam logic [8:0] OFF_EVENT_D = 9'h009;
   localparam logic [8:0] OFF_MASK_A = 9'h00A;
   localparam logic [2:0] PAGE_LOW = 3'h0;
   localparam logic [2:0] PAGE_MID = 3'h1;
   localparam logic [2:0] PAGE_HIGH = 3'h2;
   localparam logic [2:0] PAGE_TEST = 3'h3;
   localparam int PCB_AUTO_RETURN = 7;
   localparam int PCB_WRITE_MODE = 6;
   localparam logic [7:0] PAGE_SELECT_CONTROL_RST = 8'h00;
   localparam logic [7:0] PAGE_SELECT_CONTROL_WMASK = 8'hC7;
   localparam logic [7:0] MASK_A_RST = 8'h00;
   localparam logic [7:0] MASK_A_WMASK = 8'h1F;
   localparam logic [7:0] EVT_A_WMASK = 8'h1F;
   localparam logic [7:0] FAULT_LOG_RST = 8'h00;
   localparam int FLT_VDD_START = 3;
   localparam int FLT_POR = 1;
   localparam logic [7:0] CUR_LIM_MASK = 8'hF8;
   localparam int VDD_START_S = 16;
   localparam longint CLK_HZ = 100000000;
   localparam longint VDD_START_CYC = VDD_START_S * CLK_HZ;
endpackage : pseb_pkg

// ===== logic/pseb_page_ctl.sv
// One control interface's private page control register
`timescale 1ns/1ps
module pseb_page_ctl
   import pseb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic xfer_end_i,
   output logic [7:0] page_select_control_o
);
   logic [7:0] page_select_control_ff;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         page_select_control_ff <= PAGE_SELECT_CONTROL_RST;
      end else if (wr_i) begin
         page_select_control_ff <= wdata_i & PAGE_SELECT_CONTROL_WMASK;
      end else if (xfer_end_i && page_select_control_ff[PCB_AUTO_RETURN]) begin
         page_select_control_ff[2:0] <= PAGE_LOW; // [R2]
      end
   end

   assign page_select_control_o = page_select_control_ff;
endmodule : pseb_page_ctl

// ===== logic/pseb_bank.sv
// Status, fault log and first event register bank with interrupt line
// Function
// R1 - page field selects low, mid, high window; mid and high both map to the same upper window here
// R2 - auto return resets page after transfer
// R3 - write mode bit picks page/repeat
// R4 - page control at offsets 0x00 and 0x80
// R5 - one page control per interface
// R6 - status reads are live, unlatched
// R7 - system status bit layout
// R8 - input levels, analog thresholds on 0..2
// R9 - current limit bits for five regulators
// R10 - fault log records power-down causes
// R11 - early under-voltage sets bit 3
// R12 - cold start sets bit 1
// R13 - fault bits cleared by written ones
// R14 - status changes set event bits
// R15 - irq low for unmasked events
// R16 - irq held off during power-up
// R17 - event bits cleared by written ones
// R18 - events readable in multi-byte burst
// R19 - events during clear are kept
// R20 - summary bits OR of later registers
// R21 - first event register bit layout
// R22 - irq released once all cleared
// R23 - mask register gates first events
// R24 - read-only writes ignored, reserved zero
// R25 - one edge sets event once
`timescale 1ns/1ps
module pseb_bank
   import pseb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [1:0] if_sel_i,
   input wire logic acc_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic xfer_end_i,
   input wire logic low_volt_comparator_i,
   input wire logic ramp_active_i,
   input wire logic charger_wake_pin_i,
   input wire logic power_key_pin_i,
   input wire logic [15:0] gp_input_i,
   input wire logic [2:0] analog_mode_i,
   input wire logic [2:0] analog_high_i,
   input wire logic [4:0] reg_overcurrent_i,
   input wire logic [7:0] pd_cause_i,
   input wire logic cold_start_i,
   input wire logic [4:0] evt_a_src_i,
   input wire logic [7:0] evt_b_i,
   input wire logic [7:0] evt_c_i,
   input wire logic [7:0] evt_d_i,
   input wire logic [7:0] other_unmasked_i,
   input wire logic powerup_busy_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [2:0] page_o,
   output logic repeat_mode_o,
   output logic irq_out_n_o,
   output logic [7:0] fault_log_o
);
   logic [7:0] page_select_control [NUM_IF];
   logic [7:0] cur_page_select_control;
   logic [8:0] full_addr;
   logic [7:0] sys_status;
   logic [7:0] gpi_lo;
   logic [7:0] gpi_hi;
   logic [7:0] cur_lim;
   logic [7:0] event_a_ff;
   logic [7:0] nxt_event_a;
   logic [7:0] event_a;
   logic [4:0] src_prev_ff;
   logic [4:0] src_edge;
   logic [4:0] held_ff;
   logic [7:0] mask_a_ff;
   logic [7:0] fault_log_ff;
   logic [7:0] nxt_fault_log;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic irq_n_ff;
   logic irq_armed_ff;
   logic [36:0] active_cnt_ff;
   logic early_ff;
   logic clr_event_a;
   logic clr_fault;
   logic any_pending;
   logic [7:0] rd_mux;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IF; gi++) begin : g_if
         pseb_page_ctl u_page (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            // Page control sits at 0x00 and 0x80 in both windows
            .wr_i(acc_i && wr_i && if_sel_i == 2'(gi) &&
                  (addr_i == 8'h00 || addr_i == 8'h80)), // [R4] [R5]
            .wdata_i(wdata_i),
            .xfer_end_i(xfer_end_i && if_sel_i == 2'(gi)), // [R2]
            .page_select_control_o(page_select_control[gi])
         );
      end
   endgenerate

   always_comb begin
      cur_page_select_control = page_select_control[0];
      if (if_sel_i == 2'h1) begin
         cur_page_select_control = page_select_control[1];
      end else if (if_sel_i == 2'h2) begin
         cur_page_select_control = page_select_control[2];
      end
   end

   // Page bits 0 and 1, ORed, become address bit 8 of the flat map
   assign full_addr = {cur_page_select_control[0] | cur_page_select_control[1], addr_i}; // [R1]

   // Live views, power key bit inverted, the rest same polarity as the sources
   assign sys_status = {4'h0, low_volt_comparator_i, ramp_active_i,
                        charger_wake_pin_i, ~power_key_pin_i}; // [R6] [R7]
   assign gpi_lo = {gp_input_i[7:3],
                    (analog_mode_i & analog_high_i) |
                    (~analog_mode_i & gp_input_i[2:0])}; // [R8]
   assign gpi_hi = gp_input_i[15:8]; // [R8]
   assign cur_lim = {reg_overcurrent_i, 3'h0} & CUR_LIM_MASK; // [R9]

   assign clr_event_a = acc_i && wr_i && full_addr == OFF_EVENT_A;
   assign clr_fault = acc_i && wr_i && full_addr == OFF_FAULT_LOG;

   // Single-edge capture of event sources
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         src_prev_ff <= 5'h00;
      end else begin
         src_prev_ff <= evt_a_src_i;
      end
   end
   assign src_edge = evt_a_src_i & ~src_prev_ff; // [R14] [R25]

   // Edges seen during a clear are posted one cycle later
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         held_ff <= 5'h00;
      end else begin
         held_ff <= clr_event_a ? src_edge : 5'h00; // [R19]
      end
   end

   always_comb begin
      nxt_event_a = event_a_ff;
      if (clr_event_a) begin
         nxt_event_a = event_a_ff & ~(wdata_i & EVT_A_WMASK); // [R17]
         nxt_event_a = nxt_event_a | {3'h0, held_ff}; // [R19]
      end else begin
         nxt_event_a = event_a_ff | {3'h0, src_edge | held_ff}; // [R14]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         event_a_ff <= 8'h00;
      end else begin
         event_a_ff <= nxt_event_a & EVT_A_WMASK; // [R24]
      end
   end

   // Summary bits are derived, never stored
   assign event_a = {|(evt_b_i | evt_c_i | evt_d_i), |(evt_b_i | evt_c_i),
                     |evt_b_i, event_a_ff[4:0]}; // [R20] [R21]

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mask_a_ff <= MASK_A_RST;
      end else if (acc_i && wr_i && full_addr == OFF_MASK_A) begin
         mask_a_ff <= wdata_i & MASK_A_WMASK; // [R23]
      end
   end

   // Sixteen seconds of active time, counted after reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         active_cnt_ff <= 37'h0;
         early_ff <= 1'b1;
      end else if (active_cnt_ff != 37'(VDD_START_CYC)) begin
         active_cnt_ff <= active_cnt_ff + 37'h1;
      end else begin
         early_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_fault_log = fault_log_ff;
      if (clr_fault) begin
         nxt_fault_log = fault_log_ff & ~wdata_i; // [R13]
      end
      nxt_fault_log = nxt_fault_log | (pd_cause_i & 8'hF5); // [R10]
      if (pd_cause_i[2] && early_ff) begin
         nxt_fault_log[FLT_VDD_START] = 1'b1; // [R11]
      end
      if (cold_start_i) begin
         nxt_fault_log[FLT_POR] = 1'b1; // [R12]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fault_log_ff <= FAULT_LOG_RST;
      end else begin
         fault_log_ff <= nxt_fault_log;
      end
   end

   assign any_pending = |(event_a_ff[4:0] & ~mask_a_ff[4:0]) ||
                        |other_unmasked_i;

   // Power-up blanks the line; re-armed only once all is clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_armed_ff <= 1'b0;
      end else if (powerup_busy_i) begin
         irq_armed_ff <= 1'b0; // [R16]
      end else if (!any_pending) begin
         irq_armed_ff <= 1'b1; // [R16]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_n_ff <= 1'b1;
      end else begin
         irq_n_ff <= ~(irq_armed_ff && !powerup_busy_i &&
                       any_pending); // [R15] [R22]
      end
   end

   always_comb begin
      rd_mux = 8'h00; // [R24]
      unique case (full_addr)
         OFF_PAGE_SELECT_CONTROL, OFF_PAGE_SELECT_CONTROL_P1: rd_mux = cur_page_select_control;
         OFF_SYS_STATUS: rd_mux = sys_status;
         OFF_GPI_LO: rd_mux = gpi_lo;
         OFF_GPI_HI: rd_mux = gpi_hi;
         OFF_CUR_LIM: rd_mux = cur_lim;
         OFF_FAULT_LOG: rd_mux = fault_log_ff;
         OFF_EVENT_A: rd_mux = event_a;
         OFF_EVENT_B: rd_mux = evt_b_i; // [R18]
         OFF_EVENT_C: rd_mux = evt_c_i; // [R18]
         OFF_EVENT_D: rd_mux = evt_d_i; // [R18]
         OFF_MASK_A: rd_mux = mask_a_ff;
         default: rd_mux = 8'h00;
      endcase
      // Page control answers at 0x00 and 0x80 whatever the page
      if (addr_i == 8'h00 || addr_i == 8'h80) begin
         rd_mux = cur_page_select_control; // [R4]
      end
   end

   // Status read is sampled at the access cycle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= acc_i && !wr_i;
         if (acc_i && !wr_i) begin
            rdata_ff <= rd_mux; // [R6]
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         page_o <= PAGE_LOW;
         repeat_mode_o <= 1'b0;
      end else begin
         page_o <= cur_page_select_control[2:0];
         repeat_mode_o <= cur_page_select_control[PCB_WRITE_MODE]; // [R3]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fault_log_o <= FAULT_LOG_RST;
      end else begin
         fault_log_o <= fault_log_ff;
      end
   end

   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign irq_out_n_o = irq_n_ff;

   property p_clear_event;
      @(posedge sys_clk_i) disable iff (rst_i)
      clr_event_a && !(|src_edge) && !(|held_ff) |=>
         (event_a_ff & $past(wdata_i) & EVT_A_WMASK) == 8'h00;
   endproperty
   a_clear_event: assert property (p_clear_event) // [R17]
      else $error("event not cleared");

   property p_irq_masked;
      @(posedge sys_clk_i) disable iff (rst_i)
      powerup_busy_i |=> irq_out_n_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) // [R16]
      else $error("irq during power-up");

   property p_irq_release;
      @(posedge sys_clk_i) disable iff (rst_i)
      !any_pending |=> irq_out_n_o;
   endproperty
   a_irq_release: assert property (p_irq_release) // [R22]
      else $error("irq held with no event");

   property p_edge_sets;
      @(posedge sys_clk_i) disable iff (rst_i)
      src_edge[0] && !clr_event_a |=> event_a_ff[0];
   endproperty
   a_edge_sets: assert property (p_edge_sets) // [R14]
      else $error("edge lost");

   property p_held_post;
      @(posedge sys_clk_i) disable iff (rst_i)
      clr_event_a && src_edge[1] ##1 !clr_event_a |=> event_a_ff[1];
   endproperty
   a_held_post: assert property (p_held_post) // [R19]
      else $error("held event lost");

   property p_por_log;
      @(posedge sys_clk_i) disable iff (rst_i)
      cold_start_i |=> fault_log_ff[1];
   endproperty
   a_por_log: assert property (p_por_log) // [R12]
      else $error("cold start not logged");

   property p_summary;
      @(posedge sys_clk_i) disable iff (rst_i)
      event_a[5] == |evt_b_i;
   endproperty
   a_summary: assert property (p_summary) // [R20]
      else $error("summary wrong");

   property p_auto_ret;
      @(posedge sys_clk_i) disable iff (rst_i)
      xfer_end_i && !acc_i && page_select_control[if_sel_i][7] && if_sel_i != 2'h3
      |=> page_select_control[$past(if_sel_i)][2:0] == PAGE_LOW;
   endproperty
   a_auto_ret: assert property (p_auto_ret) // [R2]
      else $error("page not returned");
endmodule : pseb_bank

// ===== sim/pseb_host_model.sv
// Host model: byte accesses to the bank over its access port
`timescale 1ns/1ps
module pseb_host_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output logic [1:0] if_sel_o,
   output logic acc_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic xfer_end_o
);
   initial begin
      if_sel_o = 2'h0;
      acc_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
      xfer_end_o = 1'b0;
   end

   task automatic access(input logic [1:0] s, input logic w,
      input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
      ok = w;
      q = 8'h00;
      @(negedge sys_clk_i);
      if_sel_o = s;
      wr_o = w;
      addr_o = a;
      wdata_o = d;
      acc_o = 1'b1;
      @(negedge sys_clk_i);
      acc_o = 1'b0;
      // Released lines must not keep the old value
      addr_o = ~a;
      wdata_o = ~d;
      for (int i = 0; i < 4; i++) begin
         if (!ok && rvalid_i === 1'b1) begin
            q = rdata_i;
            ok = 1'b1;
         end
         if (!ok) @(negedge sys_clk_i);
      end
   endtask : access

   task automatic done(input logic [1:0] s);
      @(negedge sys_clk_i);
      if_sel_o = s;
      xfer_end_o = 1'b1;
      @(negedge sys_clk_i);
      xfer_end_o = 1'b0;
   endtask : done
endmodule : pseb_host_model

// ===== sim/tb_pmic_status_event_bank.sv
// Testbench of the status and event register bank
`timescale 1ns/1ps
module tb_pmic_status_event_bank;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic comp = 1'b0, ramp = 1'b0, wake = 1'b0, key_n = 1'b1;
   logic cold = 1'b0, busy = 1'b0, acc, wr_en, xend, rvalid, rmode, irq_n;
   logic [15:0] gpi = 16'h0000;
   logic [2:0] amode = 3'h0, ahigh = 3'h0, page;
   logic [4:0] oc = 5'h00, src = 5'h00;
   logic [7:0] pdc = 8'h00, eb = 8'h00, ec = 8'h00, ed = 8'h00;
   logic [7:0] oth = 8'h00, addr, wdata, rdata, flog;
   logic [1:0] if_sel;
   int miscompares = 0;
   int n_compared = 0;

   always #5 clk = ~clk;

   pseb_bank pseb_bank_inst (.sys_clk_i(clk), .rst_i(rst),
      .if_sel_i(if_sel), .acc_i(acc), .wr_i(wr_en), .addr_i(addr),
      .wdata_i(wdata), .xfer_end_i(xend), .low_volt_comparator_i(comp),
      .ramp_active_i(ramp), .charger_wake_pin_i(wake),
      .power_key_pin_i(key_n), .gp_input_i(gpi), .analog_mode_i(amode),
      .analog_high_i(ahigh), .reg_overcurrent_i(oc), .pd_cause_i(pdc),
      .cold_start_i(cold), .evt_a_src_i(src), .evt_b_i(eb), .evt_c_i(ec),
      .evt_d_i(ed), .other_unmasked_i(oth), .powerup_busy_i(busy),
      .rdata_o(rdata), .rvalid_o(rvalid), .page_o(page),
      .repeat_mode_o(rmode), .irq_out_n_o(irq_n), .fault_log_o(flog));

   pseb_host_model pseb_host_model_inst (.sys_clk_i(clk), .rdata_i(rdata),
      .rvalid_i(rvalid), .if_sel_o(if_sel), .acc_o(acc), .wr_o(wr_en),
      .addr_o(addr), .wdata_o(wdata), .xfer_end_o(xend));

   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [1:0] s, input logic [7:0] a,
      input logic [7:0] exp);
      logic [7:0] q;
      logic ok;
      pseb_host_model_inst.access(s, 1'b0, a, 8'h00, q, ok);
      if (!ok) begin
         miscompares++;
         stop_test();
      end
      chk(q, exp);
   endtask : rd_chk

   task automatic wr_reg(input logic [1:0] s, input logic [7:0] a,
      input logic [7:0] d);
      logic [7:0] q;
      logic ok;
      pseb_host_model_inst.access(s, 1'b1, a, d, q, ok);
   endtask : wr_reg

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   initial begin
      tick(5);
      rst = 1'b0;
      chk({7'h00, irq_n}, 8'h01);
      chk(flog, 8'h00);
      comp = 1'b1;
      wake = 1'b1;
      key_n = 1'b0;
      rd_chk(2'h0, 8'h01, 8'h0B);
      comp = 1'b0;
      wake = 1'b0;
      key_n = 1'b1;
      ramp = 1'b1;
      rd_chk(2'h0, 8'h01, 8'h04);
      gpi = 16'hA5C3;
      amode = 3'h1;
      rd_chk(2'h0, 8'h02, 8'hC2);
      ahigh = 3'h1;
      rd_chk(2'h0, 8'h02, 8'hC3);
      rd_chk(2'h0, 8'h03, 8'hA5);
      oc = 5'h16;
      wr_reg(2'h0, 8'h04, 8'hFF);
      rd_chk(2'h0, 8'h04, 8'hB0);
      pdc = 8'h85;
      cold = 1'b1;
      tick(1);
      pdc = 8'h00;
      cold = 1'b0;
      tick(1);
      chk(flog, 8'h8F);
      rd_chk(2'h0, 8'h05, 8'h8F);
      wr_reg(2'h0, 8'h05, 8'h81);
      rd_chk(2'h0, 8'h05, 8'h0E);
      wr_reg(2'h0, 8'h00, 8'h01);
      rd_chk(2'h0, 8'h80, 8'h01);
      chk({5'h00, page}, 8'h01);
      rd_chk(2'h0, 8'h01, 8'h00);
      rd_chk(2'h1, 8'h01, 8'h04);
      rd_chk(2'h1, 8'h00, 8'h00);
      wr_reg(2'h0, 8'h80, 8'h81);
      pseb_host_model_inst.done(2'h0);
      rd_chk(2'h0, 8'h00, 8'h80);
      chk({5'h00, page}, 8'h00);
      wr_reg(2'h1, 8'h00, 8'h78);
      tick(1);
      chk({7'h00, rmode}, 8'h01);
      rd_chk(2'h1, 8'h00, 8'h40);
      wr_reg(2'h1, 8'h00, 8'h00);
      tick(1);
      chk({7'h00, rmode}, 8'h00);
      src = 5'h10;
      tick(3);
      chk({7'h00, irq_n}, 8'h00);
      rd_chk(2'h0, 8'h06, 8'h10);
      wr_reg(2'h0, 8'h06, 8'h10);
      tick(2);
      rd_chk(2'h0, 8'h06, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      wr_reg(2'h0, 8'h0A, 8'h01);
      rd_chk(2'h0, 8'h0A, 8'h01);
      src = 5'h11;
      tick(3);
      chk({7'h00, irq_n}, 8'h01);
      rd_chk(2'h0, 8'h06, 8'h01);
      wr_reg(2'h0, 8'h0A, 8'h00);
      tick(2);
      chk({7'h00, irq_n}, 8'h00);
      busy = 1'b1;
      tick(2);
      chk({7'h00, irq_n}, 8'h01);
      busy = 1'b0;
      src = 5'h15;
      // New edge lands in the same cycle as the clear
      fork
         wr_reg(2'h0, 8'h06, 8'h05);
         begin
            @(negedge clk);
            src = 5'h17;
         end
      join
      tick(2);
      rd_chk(2'h0, 8'h06, 8'h02);
      wr_reg(2'h0, 8'h06, 8'h02);
      tick(2);
      chk({7'h00, irq_n}, 8'h01);
      oth = 8'h01;
      tick(2);
      chk({7'h00, irq_n}, 8'h00);
      oth = 8'h00;
      for (int k = 0; k < 3; k++) begin
         eb = (k == 0) ? 8'h01 : 8'h00;
         ec = (k == 1) ? 8'h80 : 8'h00;
         ed = (k == 2) ? 8'h40 : 8'h00;
         wr_reg(2'h0, 8'h06, 8'hE0);
         rd_chk(2'h0, 8'h06, k == 0 ? 8'hE0 : k == 1 ? 8'hC0 : 8'h80);
         rd_chk(2'h0, 8'h07, eb);
      end
      stop_test();
   end
endmodule : tb_pmic_status_event_bank
